//--- rtl/dcc_pkg.sv
package dcc_pkg;
   // ---------------------------------------------------------------
   // register byte addresses
   // ---------------------------------------------------------------
   localparam logic [3:0] addr_function_reg_one = 4'h0; // chip-wide control
   localparam logic [3:0] addr_chan0           = 4'h4; // channel 0 control
   localparam logic [3:0] addr_chan1           = 4'h8; // channel 1 control
   localparam logic [3:0] addr_update          = 4'hc; // write: i/o update; read: status

   // ---------------------------------------------------------------
   // function_reg_one fields
   // ---------------------------------------------------------------
   localparam int ppc_lsb   = 12;  // profile_pin_config bit 0
   localparam int ppc_msb   = 14;  // profile_pin_config bit 2
   localparam int rurd_lsb  = 0;   // ramp source, 2 bits
   localparam int level_lsb = 2;   // modulation level, 2 bits
   localparam int pd_clkin  = 4;   // clock input power-down
   localparam int pd_dacref = 5;   // dac reference power-down
   localparam int pd_sync   = 6;   // sync clock output disable
   localparam int pd_full   = 7;   // pin mode: 1 full, 0 quick recovery
   localparam int pa_clr    = 8;   // chip-wide phase accumulator clear
   localparam int pa_aclr   = 9;   // chip-wide phase auto-clear
   localparam int sw_clr    = 10;  // chip-wide sweep accumulator clear
   localparam int sw_aclr   = 11;  // chip-wide sweep auto-clear
   localparam logic [15:0] fr1_mask  = 16'h7fff; // implemented bits
   localparam logic [15:0] fr1_reset = 16'h0000; // ramp disabled, quick recovery

   // ---------------------------------------------------------------
   // channel register fields
   // ---------------------------------------------------------------
   localparam int ch_pd_dig  = 0;  // digital power-down
   localparam int ch_pd_dac  = 1;  // dac power-down
   localparam int ch_mod_lsb = 2;  // modulation type, 2 bits
   localparam int ch_sweep   = 4;  // linear sweep enable
   localparam int ch_nodwell = 5;  // no-dwell
   localparam int ch_ldsrr   = 6;  // reload sweep_ramp_rate on update
   localparam int ch_sw_clr  = 7;  // sweep accumulator clear
   localparam int ch_sw_aclr = 8;  // sweep auto-clear
   localparam int ch_pa_clr  = 9;  // phase accumulator clear
   localparam int ch_pa_aclr = 10; // phase auto-clear
   localparam int ch_match   = 11; // matched pipeline delay
   localparam int ch_fsc_lsb = 12; // dac full-scale select, 2 bits
   localparam int ch_sine    = 14; // 1 sine, 0 cosine
   localparam logic [15:0] ch_mask  = 16'h7fff; // implemented bits
   localparam logic [15:0] ch_reset = 16'h3000; // full scale, cosine, single tone

   // ---------------------------------------------------------------
   // encodings
   // ---------------------------------------------------------------
   localparam logic [1:0] rurd_off  = 2'h0; // ramp disabled
   localparam logic [1:0] rurd_p23  = 2'h1; // profile pins 2 and 3
   localparam logic [1:0] rurd_p3   = 2'h2; // profile pin 3
   localparam logic [1:0] rurd_sdio = 2'h3; // serial data pins 1 and 2
   localparam logic [1:0] mod_none  = 2'h0; // single tone
   localparam logic [1:0] mod_amp   = 2'h1; // amplitude
   localparam logic [1:0] mod_freq  = 2'h2; // frequency
   localparam logic [1:0] mod_phase = 2'h3; // phase
   localparam logic [1:0] fsc_full  = 2'h3; // full scale current
endpackage : dcc_pkg

//--- rtl/dcc_channel_control.sv
`timescale 1ns/10ps
module dcc_channel_control #(
   parameter int                 nchan     = 2,          // channel count
   parameter logic [8*16-1:0]    ppc_table = 128'h0       // pin map per code
) (
   input  wire  logic        clk,               // 50 mhz clock
   input  wire  logic        reset,             // async, active high
   input  wire  logic [3:0]  avs_address,       // byte address
   input  wire  logic        avs_read,          // read strobe
   input  wire  logic        avs_write,         // write strobe
   input  wire  logic [31:0] avs_writedata,     // write data
   input  wire  logic [3:0]  avs_byteenable,    // byte lanes
   output logic [31:0]       avs_readdata,      // read data
   output logic              avs_waitrequest,   // stall
   input  wire  logic        io_update,         // i/o update pin
   input  wire  logic        pwr_down_pin,      // power-down request
   input  wire  logic [3:0]  profile_pins,      // profile pins 0..3
   input  wire  logic [3:1]  sdio_pins,         // serial data pins 1..3
   output logic [2:0]        profile_pin_config,// active pin config
   output logic [15:0]       pin_assign,        // decoded pin roles
   output logic [1:0]        amplitude_ramp_updown, // ramp source
   output logic [1:0]        ramp_ctl,          // ramp up/down requests
   output logic              ramp_enable,       // amplitude scaling allowed
   output logic [3:0]        mod_symbol,        // active symbol
   output logic [1:0]        mod_level,         // 2/4/8/16 levels
   output logic              pd_clock_input,    // clock input down
   output logic              pd_dac_ref,        // dac ref down
   output logic              pd_sync_clock_output, // sync clock out off
   output logic              pd_digital_all,    // digital logic down
   output logic              pd_analog_all,     // all functions down
   output logic [nchan-1:0]  ch_pd_digital,     // per channel digital down
   output logic [nchan-1:0]  ch_pd_dac,         // per channel dac down
   output logic [2*nchan-1:0] ch_mod_type,      // per channel mod type
   output logic [nchan-1:0]  ch_sweep_en,       // sweep enable
   output logic [nchan-1:0]  ch_no_dwell,       // no-dwell effective
   output logic [nchan-1:0]  ch_srr_reload,     // sweep timer reload pulse
   output logic [nchan-1:0]  ch_sweep_zero,     // sweep accumulator to zero
   output logic [nchan-1:0]  ch_phase_zero,     // phase accumulator to zero
   output logic [nchan-1:0]  ch_match_delay,    // matched delay effective
   output logic [2*nchan-1:0] ch_fsc_sel,       // dac full-scale select
   output logic [nchan-1:0]  ch_sine            // 1 sine, 0 cosine
);
   // ---------------------------------------------------------------
   // staging and active registers
   // ---------------------------------------------------------------
   logic [15:0] stage_fr1,  next_stage_fr1;      // staged chip control
   logic [15:0] act_fr1,    next_act_fr1;        // active chip control
   logic [15:0] stage_ch [nchan];                // staged channel control
   logic [15:0] next_stage_ch [nchan];           // next staged channel
   logic [15:0] act_ch [nchan];                  // active channel control
   logic [15:0] next_act_ch [nchan];             // next active channel
   logic        upd_req,    next_upd_req;        // software update pending
   logic        pend,       next_pend;           // staging written since last update
   logic [31:0] rdata,      next_rdata;          // read data register
   logic        wait_q,     next_wait_q;         // waitrequest register
   logic        upd;                             // update this cycle

   assign upd = io_update | upd_req;

   // merge byte lanes into a 16-bit register
   function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] wd,
                                         input logic [3:0] be, input logic [15:0] msk);
      logic [15:0] r;
      r = old;
      if (be[0]) begin
         r[7:0] = wd[7:0];
      end
      if (be[1]) begin
         r[15:8] = wd[15:8];
      end
      return r & msk;
   endfunction : merge

   // ---------------------------------------------------------------
   // bus slave: one wait cycle, answer on second cycle
   // ---------------------------------------------------------------
   // next values of bus and register state
   always_comb begin
      logic acc;
      acc             = (avs_read | avs_write) & wait_q;
      next_wait_q     = 1'b1;
      next_rdata      = rdata;
      next_stage_fr1  = stage_fr1;
      next_act_fr1    = act_fr1;
      next_upd_req    = 1'b0;
      next_pend       = pend;
      for (int i = 0; i < nchan; i++) begin
         next_stage_ch[i] = stage_ch[i];
         next_act_ch[i]   = act_ch[i];
      end
      if (acc) begin
         next_wait_q = 1'b0; // release the master next edge
      end
      if (acc & avs_write) begin
         // writes land in staging only
         unique case (avs_address)
            dcc_pkg::addr_function_reg_one: begin
               next_stage_fr1 = merge(stage_fr1, avs_writedata, avs_byteenable,
                                      dcc_pkg::fr1_mask);
               next_pend = 1'b1;
            end
            dcc_pkg::addr_chan0: begin
               next_stage_ch[0] = merge(stage_ch[0], avs_writedata, avs_byteenable,
                                        dcc_pkg::ch_mask);
               next_pend = 1'b1;
            end
            dcc_pkg::addr_chan1: begin
               next_stage_ch[1] = merge(stage_ch[1], avs_writedata, avs_byteenable,
                                        dcc_pkg::ch_mask);
               next_pend = 1'b1;
            end
            dcc_pkg::addr_update: begin
               next_upd_req = avs_writedata[0] & avs_byteenable[0];
            end
            default: begin
            end
         endcase
      end
      if (acc & avs_read) begin
         unique case (avs_address)
            dcc_pkg::addr_function_reg_one: next_rdata = {16'h0000, stage_fr1};
            dcc_pkg::addr_chan0:            next_rdata = {16'h0000, stage_ch[0]};
            dcc_pkg::addr_chan1:            next_rdata = {16'h0000, stage_ch[1]};
            dcc_pkg::addr_update:           next_rdata = {30'h0, pwr_down_pin, pend};
            default:                        next_rdata = 32'h0000_0000;
         endcase
      end
      if (upd) begin
         // transfer staging to active on i/o update
         next_act_fr1 = stage_fr1;
         for (int i = 0; i < nchan; i++) begin
            next_act_ch[i] = stage_ch[i];
         end
         next_pend = acc & avs_write & (avs_address != dcc_pkg::addr_update);
      end
   end

   // register bus and configuration state
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         wait_q    <= 1'b1;
         rdata     <= 32'h0000_0000;
         stage_fr1 <= dcc_pkg::fr1_reset;
         act_fr1   <= dcc_pkg::fr1_reset;
         upd_req   <= 1'b0;
         pend      <= 1'b0;
         for (int i = 0; i < nchan; i++) begin
            stage_ch[i] <= dcc_pkg::ch_reset;
            act_ch[i]   <= dcc_pkg::ch_reset;
         end
      end else begin
         wait_q    <= next_wait_q;
         rdata     <= next_rdata;
         stage_fr1 <= next_stage_fr1;
         act_fr1   <= next_act_fr1;
         upd_req   <= next_upd_req;
         pend      <= next_pend;
         for (int i = 0; i < nchan; i++) begin
            stage_ch[i] <= next_stage_ch[i];
            act_ch[i]   <= next_act_ch[i];
         end
      end
   end

   assign avs_readdata    = rdata;
   assign avs_waitrequest = wait_q;

   // ---------------------------------------------------------------
   // chip-wide outputs
   // ---------------------------------------------------------------
   logic [1:0] src;                                  // active ramp source
   logic [1:0] next_ramp_ctl;                        // ramp pins by source
   assign src = act_fr1[dcc_pkg::rurd_lsb +: 2];

   // route ramp control from the selected pins
   always_comb begin
      unique case (src)
         dcc_pkg::rurd_p23:  next_ramp_ctl = profile_pins[3:2];
         dcc_pkg::rurd_p3:   next_ramp_ctl = {1'b0, profile_pins[3]};
         dcc_pkg::rurd_sdio: next_ramp_ctl = sdio_pins[2:1];
         default:            next_ramp_ctl = 2'h0;
      endcase
   end

   // chip-wide output registers
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         profile_pin_config    <= 3'h0;
         pin_assign            <= 16'h0000;
         amplitude_ramp_updown <= dcc_pkg::rurd_off;
         ramp_ctl              <= 2'h0;
         ramp_enable           <= 1'b0;
         mod_symbol            <= 4'h0;
         mod_level             <= 2'h0;
         pd_clock_input        <= 1'b0;
         pd_dac_ref            <= 1'b0;
         pd_sync_clock_output  <= 1'b0;
         pd_digital_all        <= 1'b0;
         pd_analog_all         <= 1'b0;
      end else begin
         profile_pin_config    <= act_fr1[dcc_pkg::ppc_msb:dcc_pkg::ppc_lsb];
         pin_assign            <= ppc_table[16*act_fr1[dcc_pkg::ppc_msb:dcc_pkg::ppc_lsb] +: 16];
         amplitude_ramp_updown <= src;
         ramp_ctl              <= next_ramp_ctl;
         ramp_enable           <= (src != dcc_pkg::rurd_off);
         mod_level             <= act_fr1[dcc_pkg::level_lsb +: 2];
         mod_symbol            <= profile_pins;
         pd_clock_input        <= act_fr1[dcc_pkg::pd_clkin];
         pd_dac_ref            <= act_fr1[dcc_pkg::pd_dacref];
         pd_sync_clock_output  <= act_fr1[dcc_pkg::pd_sync];
         pd_digital_all        <= pwr_down_pin;
         pd_analog_all         <= pwr_down_pin & act_fr1[dcc_pkg::pd_full];
      end
   end

   // ---------------------------------------------------------------
   // per-channel outputs
   // ---------------------------------------------------------------
   logic [nchan-1:0] upd_d;  // update seen last cycle, for auto-clear
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         upd_d <= '0;
      end else begin
         upd_d <= {nchan{upd}};
      end
   end

   for (genvar c = 0; c < nchan; c++) begin : g_ch
      logic [15:0] r;  // active channel word
      logic        sz;  // sweep zero request
      logic        pz;  // phase zero request
      assign r  = act_ch[c];
      // clear holds zero; auto-clear zeroes for one cycle after update
      assign sz = r[dcc_pkg::ch_sw_clr] | act_fr1[dcc_pkg::sw_clr] |
                  (upd_d[c] & (r[dcc_pkg::ch_sw_aclr] | act_fr1[dcc_pkg::sw_aclr]));
      assign pz = r[dcc_pkg::ch_pa_clr] | act_fr1[dcc_pkg::pa_clr] |
                  (upd_d[c] & (r[dcc_pkg::ch_pa_aclr] | act_fr1[dcc_pkg::pa_aclr]));
      // channel output registers
      always_ff @(posedge clk or posedge reset) begin
         if (reset) begin
            ch_pd_digital[c]     <= 1'b0;
            ch_pd_dac[c]         <= 1'b0;
            ch_mod_type[2*c +: 2] <= dcc_pkg::mod_none;
            ch_sweep_en[c]       <= 1'b0;
            ch_no_dwell[c]       <= 1'b0;
            ch_srr_reload[c]     <= 1'b0;
            ch_sweep_zero[c]     <= 1'b0;
            ch_phase_zero[c]     <= 1'b0;
            ch_match_delay[c]    <= 1'b0;
            ch_fsc_sel[2*c +: 2] <= dcc_pkg::fsc_full;
            ch_sine[c]           <= 1'b0;
         end else begin
            ch_pd_digital[c]     <= r[dcc_pkg::ch_pd_dig];
            ch_pd_dac[c]         <= r[dcc_pkg::ch_pd_dac];
            ch_mod_type[2*c +: 2] <= r[dcc_pkg::ch_mod_lsb +: 2];
            ch_sweep_en[c]       <= r[dcc_pkg::ch_sweep];
            ch_no_dwell[c]       <= r[dcc_pkg::ch_sweep] & r[dcc_pkg::ch_nodwell];
            ch_srr_reload[c]     <= upd & stage_ch[c][dcc_pkg::ch_ldsrr];
            ch_sweep_zero[c]     <= sz;
            ch_phase_zero[c]     <= pz;
            ch_match_delay[c]    <= r[dcc_pkg::ch_match] &
                                    (r[dcc_pkg::ch_mod_lsb +: 2] == dcc_pkg::mod_none) &
                                    ~r[dcc_pkg::ch_sweep];
            ch_fsc_sel[2*c +: 2] <= r[dcc_pkg::ch_fsc_lsb +: 2];
            ch_sine[c]           <= r[dcc_pkg::ch_sine];
         end
      end
   end

   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   sequence upd_seq;
      upd;
   endsequence
   staged_apply_a: assert property (@(posedge clk) disable iff (reset)
      upd_seq |=> act_fr1 == $past(stage_fr1)) else $error("update not applied");
   hold_no_upd_a: assert property (@(posedge clk) disable iff (reset)
      !upd |=> $stable(act_fr1)) else $error("active changed without update");
   ppc_out_a: assert property (@(posedge clk) disable iff (reset)
      1'b1 |=> profile_pin_config == $past(act_fr1[dcc_pkg::ppc_msb:dcc_pkg::ppc_lsb]))
      else $error("ppc wrong");
   ramp_off_a: assert property (@(posedge clk) disable iff (reset)
      src == dcc_pkg::rurd_off |=> !ramp_enable && ramp_ctl == 2'h0) else $error("ramp active");
   full_pd_a: assert property (@(posedge clk) disable iff (reset)
      pwr_down_pin && !act_fr1[dcc_pkg::pd_full] |=> pd_digital_all && !pd_analog_all)
      else $error("quick recovery wrong");
   pin_up_a: assert property (@(posedge clk) disable iff (reset)
      !pwr_down_pin |=> !pd_digital_all && !pd_analog_all) else $error("pin up ignored");
   nodwell_a: assert property (@(posedge clk) disable iff (reset)
      ch_no_dwell[0] |-> ch_sweep_en[0]) else $error("no-dwell without sweep");
   match_a: assert property (@(posedge clk) disable iff (reset)
      ch_match_delay[0] |-> ch_mod_type[1:0] == dcc_pkg::mod_none) else $error("match in mod");
   wait_a: assert property (@(posedge clk) disable iff (reset)
      avs_read && avs_waitrequest |=> !avs_waitrequest) else $error("no answer");

   // channel 0 phase auto-clear: update, then settings stay put without a hard clear
   sequence ph_aclr_upd_seq;
      upd ##1 (!upd && act_ch[0][dcc_pkg::ch_pa_aclr] && !act_ch[0][dcc_pkg::ch_pa_clr] &&
               !act_fr1[dcc_pkg::pa_clr]);
   endsequence
   // one zero cycle, then the accumulator is let go again
   sequence ph_pulse_seq;
      ch_phase_zero[0] ##1 !ch_phase_zero[0];
   endsequence
   aclr_pulse_a: assert property (@(posedge clk) disable iff (reset)
      ph_aclr_upd_seq |=> ph_pulse_seq) else $error("auto-clear not one pulse");
   // a hard clear keeps the accumulator at zero every cycle
   sweep_hold_a: assert property (@(posedge clk) disable iff (reset)
      act_ch[1][dcc_pkg::ch_sw_clr] |=> ch_sweep_zero[1]) else $error("sweep clear not held");
   // sweep timer reload follows each update when the option is set
   srr_reload_a: assert property (@(posedge clk) disable iff (reset)
      upd && stage_ch[0][dcc_pkg::ch_ldsrr] |=> ch_srr_reload[0])
      else $error("sweep timer not reloaded");
   srr_quiet_a: assert property (@(posedge clk) disable iff (reset)
      !upd |=> !ch_srr_reload[0]) else $error("reload without update");
   // software power-downs track the active copy
   pd_soft_a: assert property (@(posedge clk) disable iff (reset)
      1'b1 |=> pd_clock_input == $past(act_fr1[dcc_pkg::pd_clkin]) &&
               pd_dac_ref == $past(act_fr1[dcc_pkg::pd_dacref]) &&
               pd_sync_clock_output == $past(act_fr1[dcc_pkg::pd_sync]))
      else $error("software power-down wrong");
   // chip-wide level setting reaches its output
   level_out_a: assert property (@(posedge clk) disable iff (reset)
      1'b1 |=> mod_level == $past(act_fr1[dcc_pkg::level_lsb +: 2]))
      else $error("level wrong");
   // channel 1 dac select and channel 0 waveform select reach their outputs
   fsc_out_a: assert property (@(posedge clk) disable iff (reset)
      1'b1 |=> ch_fsc_sel[3:2] == $past(act_ch[1][dcc_pkg::ch_fsc_lsb +: 2]))
      else $error("full-scale select wrong");
   sine_out_a: assert property (@(posedge clk) disable iff (reset)
      1'b1 |=> ch_sine[0] == $past(act_ch[0][dcc_pkg::ch_sine]))
      else $error("waveform select wrong");
endmodule : dcc_channel_control

//--- bench/dcc_ctrl_partner.sv
`timescale 1ns/10ps
// ---------------------------------------------------------------
// external controller: drives update, power-down and data pins
// ---------------------------------------------------------------
module dcc_ctrl_partner (
   input  wire  logic       clk,          // system clock
   input  wire  logic       reset,        // async, active high
   input  wire  logic       upd_req,      // one-cycle update request
   input  wire  logic       pd_req,       // power-down request level
   input  wire  logic [3:0] prof_req,     // profile pin levels
   input  wire  logic [2:0] sdio_req,     // serial data pin levels
   output logic             io_update,    // i/o update pin
   output logic             pwr_down_pin, // high down, low up
   output logic [3:0]       profile_pins, // profile pins 0..3
   output logic [3:1]       sdio_pins     // serial data pins 1..3
);
   // pins move just after the edge and hold until the next request
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         io_update    <= 1'b0;
         pwr_down_pin <= 1'b0;
         profile_pins <= 4'h0;
         sdio_pins    <= 3'h0;
      end else begin
         io_update    <= upd_req;
         pwr_down_pin <= pd_req;
         profile_pins <= prof_req;
         sdio_pins    <= sdio_req;
      end
   end
endmodule : dcc_ctrl_partner

//--- bench/dcc_channel_control_bench.sv
`timescale 1ns/10ps
module dcc_channel_control_bench;
   // ---------------------------------------------------------------
   // signals
   // ---------------------------------------------------------------
   localparam logic [127:0] tbl = 128'h7777_6666_5555_4444_3333_2222_1111_0000; // pin map
   logic        clk, reset, avs_read, avs_write, avs_waitrequest, upd_req, pd_req, io_update;
   logic        pwr_down_pin, ramp_enable, pd_clock_input, pd_dac_ref, pd_sync_clock_output;
   logic        pd_digital_all, pd_analog_all;
   logic [3:0]  avs_address, avs_byteenable, prof_req, profile_pins, mod_symbol;
   logic [3:0]  ch_mod_type, ch_fsc_sel;
   logic [31:0] avs_writedata, avs_readdata, rd;
   logic [2:0]  sdio_req, profile_pin_config;
   logic [3:1]  sdio_pins;
   logic [15:0] pin_assign;
   logic [1:0]  amplitude_ramp_updown, ramp_ctl, mod_level, ch_pd_digital, ch_pd_dac;
   logic [1:0]  ch_sweep_en, ch_no_dwell, ch_srr_reload, ch_sweep_zero, ch_phase_zero;
   logic [1:0]  ch_match_delay, ch_sine;
   int          num_errors, comparisons, c_srr0, c_srr1, c_pz0, c_sz0, c_sz1;

   dcc_channel_control #(.nchan(2), .ppc_table(tbl)) dut (.clk, .reset, .avs_address,
      .avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata,
      .avs_waitrequest, .io_update, .pwr_down_pin, .profile_pins, .sdio_pins,
      .profile_pin_config, .pin_assign, .amplitude_ramp_updown, .ramp_ctl, .ramp_enable,
      .mod_symbol, .mod_level, .pd_clock_input, .pd_dac_ref, .pd_sync_clock_output,
      .pd_digital_all, .pd_analog_all, .ch_pd_digital, .ch_pd_dac, .ch_mod_type,
      .ch_sweep_en, .ch_no_dwell, .ch_srr_reload, .ch_sweep_zero, .ch_phase_zero,
      .ch_match_delay, .ch_fsc_sel, .ch_sine);
   dcc_ctrl_partner ext (.clk, .reset, .upd_req, .pd_req, .prof_req, .sdio_req,
      .io_update, .pwr_down_pin, .profile_pins, .sdio_pins);

   // ---------------------------------------------------------------
   // tasks
   // ---------------------------------------------------------------
   // one avalon access, held until waitrequest is sampled low
   task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
      int n;
      n = 0;
      avs_address   <= a;
      avs_writedata <= d;
      avs_write     <= wr;
      avs_read      <= !wr;
      do begin
         @(posedge clk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 50);
      rd = avs_readdata;
      avs_write <= 1'b0;
      avs_read  <= 1'b0;
      if (n >= 50) begin
         num_errors++;
         $display("mismatch at %0t: bus hang", $time);
      end
      @(posedge clk);
   endtask : bus

   // compare and count
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      comparisons++;
      if (got !== exp) begin
         num_errors++;
         $display("mismatch at %0t: %s got %h exp %h", $time, m, got, exp);
      end
   endtask : chk

   // update pulse, then tally pulses over the following cycles
   task automatic upd();
      {c_srr0, c_srr1, c_pz0, c_sz0, c_sz1} = '0;
      upd_req <= 1'b1;
      @(posedge clk);
      upd_req <= 1'b0;
      repeat (6) begin
         @(posedge clk);
         c_srr0 += ch_srr_reload[0];
         c_srr1 += ch_srr_reload[1];
         c_pz0  += ch_phase_zero[0];
         c_sz0  += ch_sweep_zero[0];
         c_sz1  += ch_sweep_zero[1];
      end
   endtask : upd

   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", comparisons, num_errors);
      if (num_errors == 0 && comparisons > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : give_verdict

   // ---------------------------------------------------------------
   // clock, watchdog, tests
   // ---------------------------------------------------------------
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   initial begin
      #1000000;
      num_errors++;
      give_verdict();
   end

   initial begin
      {reset, avs_read, avs_write, upd_req, pd_req} = 5'h10;
      {avs_address, avs_writedata, prof_req, sdio_req} = '0;
      avs_byteenable = 4'h3;
      repeat (4) @(posedge clk);
      reset <= 1'b0;
      @(posedge clk);
      bus(1'b0, 4'h0, 32'h0);
      chk(rd, 32'h0, "fr1 reset");
      bus(1'b0, 4'h4, 32'h0);
      chk(rd, 32'h3000, "ch0 reset");
      bus(1'b0, 4'h8, 32'h0);
      chk(rd, 32'h3000, "ch1 reset");
      chk({ch_fsc_sel, ch_sine, ch_pd_digital, ch_pd_dac}, 32'h3c0, "ch outs");
      chk({amplitude_ramp_updown, ramp_enable, ch_match_delay}, 32'h0, "ramp off");
      $display("test reset done");
      bus(1'b1, 4'h0, 32'h500c);
      bus(1'b1, 4'h2, 32'hffff);
      bus(1'b0, 4'h2, 32'h0);
      chk(rd, 32'h0, "unmapped");
      bus(1'b0, 4'h0, 32'h0);
      chk(rd, 32'h500c, "fr1 back");
      bus(1'b0, 4'hc, 32'h0);
      chk(rd, 32'h1, "pending");
      chk(profile_pin_config, 3'h0, "staged only");
      upd();
      chk(profile_pin_config, 3'h5, "ppc");
      chk(pin_assign, 16'h5555, "pin map");
      chk(mod_level, 2'h3, "level");
      bus(1'b0, 4'hc, 32'h0);
      chk(rd, 32'h0, "applied");
      prof_req <= 4'ha;
      sdio_req <= 3'h3;
      repeat (4) @(posedge clk);
      chk(mod_symbol, 4'ha, "symbol");
      for (int i = 0; i < 4; i++) begin
         bus(1'b1, 4'h0, 32'h500c | i);
         upd();
         chk(amplitude_ramp_updown, i[1:0], "ramp src");
         chk(ramp_enable, i != 0, "ramp en");
         chk(ramp_ctl, (i == 1) ? 2'h2 : (i == 2) ? 2'h1 : i[1:0], "ramp pins");
      end
      $display("test chip settings done");
      bus(1'b1, 4'h0, 32'h70);
      upd();
      chk({pd_clock_input, pd_dac_ref, pd_sync_clock_output}, 3'h7, "sw pd");
      pd_req <= 1'b1;
      repeat (4) @(posedge clk);
      chk({pd_digital_all, pd_analog_all}, 2'h2, "quick pd");
      bus(1'b1, 4'h0, 32'hf0);
      bus(1'b0, 4'hc, 32'h0);
      chk(rd, 32'h3, "status");
      chk({pd_digital_all, pd_analog_all}, 2'h2, "mode staged");
      bus(1'b1, 4'hc, 32'h1);
      repeat (2) @(posedge clk);
      chk({pd_digital_all, pd_analog_all}, 2'h3, "full pd");
      pd_req <= 1'b0;
      repeat (4) @(posedge clk);
      chk({pd_digital_all, pd_analog_all}, 2'h0, "pin up");
      $display("test power done");
      for (int m = 0; m < 4; m++) begin
         bus(1'b1, 4'h4, 32'h5821 | (m << 2));
         bus(1'b1, 4'h8, 32'h2032 | ((3 - m) << 2));
         upd();
         chk(ch_mod_type, {2'(3 - m), 2'(m)}, "mod type");
         chk(ch_match_delay, {1'b0, m == 0}, "match");
         chk({ch_sweep_en, ch_no_dwell}, 4'ha, "sweep");
         chk({ch_pd_digital, ch_pd_dac}, 4'h6, "ch pd");
         chk({ch_fsc_sel, ch_sine}, 6'h25, "dac");
      end
      $display("test channels done");
      bus(1'b1, 4'h4, 32'h3440);
      bus(1'b1, 4'h8, 32'h3080);
      upd();
      upd();
      chk(c_srr0, 32'd1, "srr reload 0");
      chk(c_srr1, 32'd0, "srr reload 1");
      chk(c_pz0, 32'd1, "auto clear once");
      chk(c_sz0, 32'd0, "sweep clear 0");
      chk(c_sz1, 32'd6, "sweep clear hold");
      bus(1'b1, 4'h8, 32'h3000);
      upd();
      chk(ch_sweep_zero, 2'h0, "clear release");
      bus(1'b1, 4'h0, 32'h800);
      upd();
      chk(c_sz0, 32'd1, "chip auto clear 0");
      chk(c_sz1, 32'd1, "chip auto clear 1");
      $display("test accumulators done");
      give_verdict();
   end
endmodule : dcc_channel_control_bench
